// ---- verification/test_ues_top.sv ----
/*
  test_ues_top: self-checking bench for ues_top against an integer model.
  assumes: ues_pkg compiled first; ues_usb_model drives the event inputs.
*/
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module test_ues_top;
  logic ref_clk = 1'b0, resetn = 1'b0;
  logic [3:0] fire_req = 4'h0, ev;
  logic [7:0] hold_cyc = 8'h06;
  logic usb_logic_reset, device_logic_reset, reset_output_pin, rom_shadow_bit, connect_bit, irq;
  logic [17:0] awaddr = 18'h0_0000, araddr = 18'h0_0000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rd;
  int n_fail = 0, n_tests = 0, exp_flags = 0, exp_irq = 0, mask = 0, ctrl = 0, k0;
  localparam logic [17:0] STAT = ues_pkg::EVT_STATUS_ADDR;
  always #5 ref_clk = ~ref_clk;
  ues_usb_model u_host (.ref_clk(ref_clk), .resetn(resetn), .fire_req(fire_req), .hold_cyc(hold_cyc),
    .ev_level(ev));
  ues_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .usb_reset_in(ev[3]), .usb_suspend_in(ev[2]),
    .usb_resume_in(ev[1]), .usb_sof_in(ev[0]), .usb_logic_reset(usb_logic_reset),
    .device_logic_reset(device_logic_reset), .reset_output_pin(reset_output_pin),
    .rom_shadow_bit(rom_shadow_bit), .connect_bit(connect_bit), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  // ------------------------------------------------------------------
  // closing report and axi4-lite master tasks
  // ------------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [17:0] a, input logic [31:0] d);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp; bready <= 1'b0; return;
      end
    end
    n_fail++;
    print_verdict();
  endtask
  task automatic axi_rd(input logic [17:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rresp; rd = rdata; rready <= 1'b0; return;
      end
    end
    n_fail++;
    print_verdict();
  endtask
  // one event from the host; the usb reset lane also checks its side effects mid-event
  task automatic fire(input int k);
    hold_cyc <= 8'(6 + $urandom % 7);
    fire_req <= 4'(1 << k);
    @(posedge ref_clk);
    fire_req <= 4'h0;
    repeat (5) @(posedge ref_clk);
    if (k == 3) begin
      `CHK("usb_logic_reset", 1'b1, usb_logic_reset)
      `CHK("device_logic_reset", 1'(ctrl & 1), device_logic_reset)
      `CHK("reset_output_pin", 1'(ctrl & 1), reset_output_pin)
    end
    repeat (30) @(posedge ref_clk);
    exp_flags |= 1 << k;
    exp_irq |= 1 << k;
    if (k == 3 && (ctrl & 1)) begin
      ctrl &= 6;
      mask = 0;
    end
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32'h1883ab51));
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    axi_rd(STAT);
    `CHK("status after reset", 32'h0, rd)
    axi_wr(ues_pkg::IRQ_MASK_ADDR, 32'hf);
    mask = 15;
    k0 = $urandom % 4;
    for (int i = 0; i < 4; i++) begin
      fire((k0 + i) % 4);
      axi_rd(STAT);
      `CHK("status flags", 32'(exp_flags << 4), rd)
      `CHK("irq level", 1'((exp_irq & mask) != 0), irq)
      axi_rd(ues_pkg::IRQ_STATUS_ADDR);
      `CHK("irq status", 32'(exp_irq), rd)
      exp_irq = 0;
      `CHK("irq after read", 1'b0, irq)
    end
    // vector write acknowledges every flag, whatever data it carries
    axi_wr(ues_pkg::IRQ_VECTOR_ADDR, $urandom);
    `CHK("vector bresp", ues_pkg::RESP_OKAY, r)
    exp_flags = 0;
    axi_rd(STAT);
    `CHK("status cleared", 32'h0, rd)
    // full reset keeps the shadow and connect bits
    axi_wr(ues_pkg::USB_CTRL_ADDR, 32'h7);
    ctrl = 7;
    fire(3);
    `CHK("rom_shadow_bit", 1'b1, rom_shadow_bit)
    `CHK("connect_bit", 1'b1, connect_bit)
    axi_rd(ues_pkg::USB_CTRL_ADDR);
    `CHK("ctrl after full reset", 32'(ctrl), rd)
    axi_rd(STAT);
    `CHK("reset flag", 32'(exp_flags << 4), rd)
    `CHK("irq masked", 1'b0, irq)
    axi_rd(ues_pkg::IRQ_STATUS_ADDR);
    `CHK("irq status full reset", 32'(exp_irq), rd)
    exp_irq = 0;
    // only the sof lane unmasked
    axi_wr(ues_pkg::IRQ_MASK_ADDR, 32'h1);
    mask = 1;
    fire(1);
    `CHK("irq resume masked", 1'b0, irq)
    fire(0);
    `CHK("irq sof", 1'b1, irq)
    // the status word is read only: a write is refused and every flag stays
    axi_wr(STAT, 32'hffff_ffff);
    `CHK("status write bresp", ues_pkg::RESP_SLVERR, r)
    axi_rd(STAT);
    `CHK("status after write", 32'(exp_flags << 4), rd)
    // unmapped places answer with an error
    axi_rd(18'h0_0100);
    `CHK("unmapped rresp", ues_pkg::RESP_SLVERR, r)
    `CHK("unmapped rdata", 32'h0, rd)
    axi_wr(18'h0_0104, 32'hffff_ffff);
    `CHK("unmapped bresp", ues_pkg::RESP_SLVERR, r)
    print_verdict();
  end
endmodule // test_ues_top

// ---- verification/ues_usb_model.sv ----
/*
  ues_usb_model: stands in for the usb logic, raising event levels.
  assumes: fire_req is a one-cycle request per lane; hold_cyc is at least 3.
*/
`timescale 1ns/1ps
module ues_usb_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] fire_req,
  input wire logic [7:0] hold_cyc,
  output logic [3:0] ev_level
);
  logic [7:0] cnt_reg [4];
  // ------------------------------------------------------------------
  // event levels, lanes {reset, suspend, resume, sof}
  // ------------------------------------------------------------------
  // a lane is high for hold_cyc cycles, so slow and quick hosts both appear
  always_ff @(posedge ref_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (!resetn) begin
        cnt_reg[k] <= 8'h00;
      end else if (fire_req[k]) begin
        cnt_reg[k] <= hold_cyc; // host reset, suspend, resume, sof packet
      end else if (cnt_reg[k] != 8'h00) begin
        cnt_reg[k] <= cnt_reg[k] - 8'h01;
      end
    end
  end
  // idle level is low: no event on the bus
  always_comb begin
    for (int k = 0; k < 4; k++) ev_level[k] = (cnt_reg[k] != 8'h00);
  end
endmodule // ues_usb_model

// ---- verilog/ues_edge.sv ----
/*
  ues_edge: rising edge pulse detector, one lane per event.
  assumes: inputs are already synchronous to ref_clk.
*/
`timescale 1ns/1ps
module ues_edge #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] rise_pulse
);
  logic [WIDTH-1:0] prev_reg;

  // remember last level
  always_ff @(posedge ref_clk) begin
    if (!resetn) prev_reg <= '0;
    else prev_reg <= level_in;
  end

  // one pulse per lane on a low to high change
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_lane
      assign rise_pulse[i] = level_in[i] & ~prev_reg[i];
    end
  endgenerate
endmodule // ues_edge

// ---- verilog/ues_pkg.sv ----
/*
  ues_pkg: constants shared by the usb event status flag block.
  assumes: included first in compile order; nothing imported, used as ues_pkg::name.
*/
package ues_pkg;
  // ------------------------------------------------------------------
  // register map: word indices, byte address on the bus is four times the index
  // ------------------------------------------------------------------
  localparam logic [15:0] EVT_STATUS_IDX = 16'hfffe;
  localparam logic [15:0] IRQ_VECTOR_IDX = 16'hfffc;
  localparam logic [15:0] USB_CTRL_IDX = 16'hfff8;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hfff4;
  localparam logic [15:0] IRQ_STATUS_IDX = 16'hfff0;
  localparam logic [17:0] EVT_STATUS_ADDR = {EVT_STATUS_IDX, 2'h0};
  localparam logic [17:0] IRQ_VECTOR_ADDR = {IRQ_VECTOR_IDX, 2'h0};
  localparam logic [17:0] USB_CTRL_ADDR = {USB_CTRL_IDX, 2'h0};
  localparam logic [17:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'h0};
  localparam logic [17:0] IRQ_STATUS_ADDR = {IRQ_STATUS_IDX, 2'h0};
  localparam logic [17:0] WORD_MASK = 18'h3_fffc;

  // ------------------------------------------------------------------
  // field positions in usb_event_status
  // ------------------------------------------------------------------
  localparam int RESET_BIT = 7;
  localparam int SUSPEND_BIT = 6;
  localparam int RESUME_BIT = 5;
  localparam int SOF_BIT = 4;
  localparam int NUM_EVT = 4;

  // usb control register fields
  localparam int FULL_RST_BIT = 0;
  localparam int ROM_SHADOW_BIT = 1;
  localparam int CONNECT_BIT = 2;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // timing: reset output stretch and nominal frame period
  localparam int RST_OUT_NS = 100;
  localparam int CLK_NS = 10;
  localparam int RST_OUT_CYC = (RST_OUT_NS + CLK_NS - 1) / CLK_NS;
  localparam int FRAME_US = 1000;
  localparam int FRAME_CYC = FRAME_US * 1000 / CLK_NS;
endpackage

// ---- verilog/ues_sync.sv ----
/*
  ues_sync: two flip-flop synchroniser for a group of level inputs.
  assumes: inputs are levels from outside ref_clk's domain, held longer than two cycles.
*/
`timescale 1ns/1ps
module ues_sync #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // ues_sync

// ---- verilog/ues_top.sv ----
/*
  ues_top: upper half of the usb event status register with its reset side effects,
  an interrupt status/mask pair and an axi4-lite slave.
  assumes: event inputs are levels from the usb logic in another timing domain;
  the bus master keeps one write and one read outstanding at most.
*/
// Our own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module ues_top (
  input wire logic ref_clk,
  input wire logic resetn,
  // usb side event levels
  input wire logic usb_reset_in,
  input wire logic usb_suspend_in,
  input wire logic usb_resume_in,
  input wire logic usb_sof_in,
  // reset side effects and interrupt request
  output logic usb_logic_reset,
  output logic device_logic_reset,
  output logic reset_output_pin,
  output logic rom_shadow_bit,
  output logic connect_bit,
  output logic irq,
  // axi4-lite slave
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int N = ues_pkg::NUM_EVT;

  // ----------------------------------------------------------------
  // event capture
  // ----------------------------------------------------------------
  logic [N-1:0] evt_async;
  logic [N-1:0] evt_sync;
  logic [N-1:0] evt_rise;
  // lane order: 3 reset, 2 suspend, 1 resume, 0 sof
  assign evt_async = {usb_reset_in, usb_suspend_in, usb_resume_in, usb_sof_in};

  ues_sync #(.WIDTH(N)) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .async_in(evt_async),
    .sync_out(evt_sync)
  );

  ues_edge #(.WIDTH(N)) u_edge (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .level_in(evt_sync),
    .rise_pulse(evt_rise)
  );

  wire usb_rst_evt = evt_rise[3];
  wire usb_rst_level = evt_sync[3];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [N-1:0] flag_reg;
  logic [N-1:0] flag_next;
  logic [N-1:0] irq_stat_reg;
  logic [N-1:0] irq_stat_next;
  logic [N-1:0] irq_mask_reg;
  logic full_rst_en_reg;
  logic full_rst_busy_reg;
  logic rom_shadow_reg;
  logic connect_reg;
  logic [7:0] rst_cnt_reg;
  logic [7:0] rst_cnt_next;

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic aw_full_reg;
  logic w_full_reg;
  logic [17:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire [17:0] wr_word = aw_addr_reg & ues_pkg::WORD_MASK;
  wire wr_vector = wr_fire & (wr_word == ues_pkg::IRQ_VECTOR_ADDR);
  wire wr_ctrl = wr_fire & (wr_word == ues_pkg::USB_CTRL_ADDR) & w_strb_reg[0];
  wire wr_mask = wr_fire & (wr_word == ues_pkg::IRQ_MASK_ADDR) & w_strb_reg[0];
  wire wr_ok = (wr_word == ues_pkg::IRQ_VECTOR_ADDR) | (wr_word == ues_pkg::USB_CTRL_ADDR) |
               (wr_word == ues_pkg::IRQ_MASK_ADDR);
  // address and data may arrive in either order; each holds until the response goes
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready = ~w_full_reg;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= 18'h0_0000;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ues_pkg::RESP_OKAY;
    end else begin
      if (aw_take) aw_addr_reg <= s_axi_awaddr;
      if (aw_take) aw_full_reg <= 1'b1;
      if (w_take) w_data_reg <= s_axi_wdata;
      if (w_take) w_strb_reg <= s_axi_wstrb;
      if (w_take) w_full_reg <= 1'b1;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? ues_pkg::RESP_OKAY : ues_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [17:0] rd_word = s_axi_araddr & ues_pkg::WORD_MASK;
  wire rd_status = rd_word == ues_pkg::EVT_STATUS_ADDR;
  wire rd_ctrl = rd_word == ues_pkg::USB_CTRL_ADDR;
  wire rd_mask = rd_word == ues_pkg::IRQ_MASK_ADDR;
  wire rd_istat = rd_word == ues_pkg::IRQ_STATUS_ADDR;
  wire rd_vec = rd_word == ues_pkg::IRQ_VECTOR_ADDR;
  wire rd_ok = rd_status | rd_ctrl | rd_mask | rd_istat | rd_vec;
  // one register per aligned word, so the status byte sits in the low lane
  wire [7:0] status_byte = {flag_reg, 4'h0};
  wire [31:0] rd_val = rd_status ? {24'h00_0000, status_byte} :
                       rd_ctrl ? {29'h0, connect_reg, rom_shadow_reg, full_rst_en_reg} :
                       rd_mask ? {28'h0, irq_mask_reg} :
                       rd_istat ? {28'h0, irq_stat_reg} : 32'h0000_0000;
  wire rd_istat_clr = ar_take & rd_istat;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ues_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? ues_pkg::RESP_OKAY : ues_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // event flags and reset side effects
  // ----------------------------------------------------------------
  // full device reset clears only the full reset enable and the irq mask
  // the enable clears itself at once, so the busy bit carries the reset to its end
  wire dev_rst = usb_rst_level & (full_rst_en_reg | full_rst_busy_reg);
  // flags: set by hardware, cleared by a vector write, set wins
  assign flag_next = (wr_vector ? '0 : flag_reg) | evt_rise;
  // sof is paced by the host alone, nominally FRAME_CYC apart; no local timer sets it
  assign irq_stat_next = (rd_istat_clr ? '0 : irq_stat_reg) | evt_rise;
  // stretch reset pin so a short usb reset still gives a clean pulse
  assign rst_cnt_next = (full_rst_en_reg & usb_rst_evt) ? 8'(ues_pkg::RST_OUT_CYC) :
                        (rst_cnt_reg != 8'h00) ? rst_cnt_reg - 8'h01 : 8'h00;

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      flag_reg <= ues_pkg::STATUS_RESET[7:4];
      irq_stat_reg <= ues_pkg::MASK_RESET;
      rst_cnt_reg <= 8'h00;
    end else begin
      flag_reg <= flag_next;
      irq_stat_reg <= irq_stat_next;
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  // remembers that this usb reset began with the full reset enabled
  always_ff @(posedge ref_clk) begin
    if (!resetn) full_rst_busy_reg <= 1'b0;
    else full_rst_busy_reg <= dev_rst;
  end

  // kept across a full usb reset: only resetn or a control write changes them
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rom_shadow_reg <= ues_pkg::CTRL_RESET[ues_pkg::ROM_SHADOW_BIT];
      connect_reg <= ues_pkg::CTRL_RESET[ues_pkg::CONNECT_BIT];
    end else if (wr_ctrl) begin
      rom_shadow_reg <= w_data_reg[ues_pkg::ROM_SHADOW_BIT];
      connect_reg <= w_data_reg[ues_pkg::CONNECT_BIT];
    end
  end

  // cleared by a full usb reset like other device logic
  always_ff @(posedge ref_clk) begin
    if (!resetn || dev_rst) begin
      full_rst_en_reg <= ues_pkg::CTRL_RESET[ues_pkg::FULL_RST_BIT];
      irq_mask_reg <= ues_pkg::MASK_RESET;
    end else begin
      if (wr_ctrl) full_rst_en_reg <= w_data_reg[ues_pkg::FULL_RST_BIT];
      if (wr_mask) irq_mask_reg <= w_data_reg[N-1:0];
    end
  end

  // usb sub-block reset follows the synchronised reset level
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      usb_logic_reset <= 1'b0;
      device_logic_reset <= 1'b0;
      reset_output_pin <= 1'b0;
    end else begin
      usb_logic_reset <= usb_rst_level;
      device_logic_reset <= dev_rst;
      reset_output_pin <= dev_rst | (rst_cnt_reg != 8'h00);
    end
  end

  assign rom_shadow_bit = rom_shadow_reg;
  assign connect_bit = connect_reg;
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  rst_flag_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    usb_rst_evt |=> flag_reg[3])
    else $error("usb reset did not set flag");
  usb_logic_rst_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    usb_rst_level |=> usb_logic_reset)
    else $error("usb logic not reset");
  full_rst_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (full_rst_en_reg && usb_rst_level) |=> (device_logic_reset && !full_rst_en_reg))
    else $error("full reset missed");
  keep_bits_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (dev_rst && !wr_ctrl) |=> ($stable(connect_reg) && $stable(rom_shadow_reg)))
    else $error("kept bit changed in full reset");
  rst_pin_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (full_rst_en_reg && usb_rst_evt) |=> reset_output_pin [*2])
    else $error("reset pin not driven");
  rst_pin_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!full_rst_en_reg && !full_rst_busy_reg && rst_cnt_reg == 8'h00) |=> !reset_output_pin)
    else $error("reset pin without enable");
  vec_clear_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wr_vector && evt_rise == '0) |=> flag_reg == '0)
    else $error("vector write did not clear");
  flag_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!wr_vector) |=> ((flag_reg & $past(flag_reg)) == $past(flag_reg)))
    else $error("flag lost without clear");
  susp_res_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (evt_rise[2] || evt_rise[1]) |=> (flag_reg[2] || !$past(evt_rise[2])) && (flag_reg[1] || !$past(evt_rise[1])))
    else $error("suspend or resume flag not set");
  sof_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    evt_rise[0] |=> ##1 (flag_reg[0] || $past(wr_vector)))
    else $error("sof flag not set");
  reset_zero_a: assert property (@(posedge ref_clk)
    !resetn |=> flag_reg == '0)
    else $error("flags not zero after reset");
  // full reset span, register access and bus answers
  full_rst_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (full_rst_busy_reg && usb_rst_level) |=> device_logic_reset)
    else $error("full reset ended early");
  full_rst_end_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    !usb_rst_level |=> !device_logic_reset)
    else $error("device reset without usb reset");
  status_ro_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (wr_fire && wr_word == ues_pkg::EVT_STATUS_ADDR) |=>
      (s_axi_bresp == ues_pkg::RESP_SLVERR && flag_reg == ($past(flag_reg) | $past(evt_rise))))
    else $error("status register written");
  sof_host_only_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (!evt_rise[0] && !flag_reg[0]) |=> !flag_reg[0])
    else $error("sof flag without host sof");
  stat_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ar_take && rd_status) |=>
      (s_axi_rvalid && s_axi_rresp == ues_pkg::RESP_OKAY && s_axi_rdata[7:4] == $past(flag_reg)))
    else $error("status read wrong");
  istat_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    (rd_istat_clr && evt_rise == '0) |=> irq_stat_reg == '0)
    else $error("irq status not cleared by read");
  wr_resp_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write response missing");
  rd_resp_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    ar_take |=> s_axi_rvalid)
    else $error("read response missing");
endmodule // ues_top
